// ===== rtl/occ_pkg.sv
// package for the output compare channel: register map, fields, modes
package occ_pkg;
    // register word offsets (byte addresses)
    localparam logic [7:0] OCC_CTRL_OFF = 8'h00;
    localparam logic [7:0] OCC_PRI_OFF  = 8'h10;
    localparam logic [7:0] OCC_SEC_OFF  = 8'h20;
    // alias offsets added to each register base
    localparam logic [3:0] OCC_ALIAS_CLR = 4'h4;
    localparam logic [3:0] OCC_ALIAS_SET = 4'h8;
    localparam logic [3:0] OCC_ALIAS_INV = 4'hC;
    // control field positions
    localparam int OCC_ON_BIT    = 15;
    localparam int OCC_IDLE_BIT  = 13;
    localparam int OCC_WIDE_BIT  = 5;
    localparam int OCC_FLT_BIT   = 4;
    localparam int OCC_TSEL_BIT  = 3;
    // writable control bits
    // enable, stop-in-idle, wide, timebase and mode; flag bit 4 read only
    localparam logic [31:0] OCC_CTRL_WMASK = 32'h0000_A02F;
    localparam logic [31:0] OCC_CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] OCC_VAL_RST    = 32'h0000_0000;
    // compare modes
    typedef enum logic [2:0] {
        OCC_M_OFF    = 3'b000,
        OCC_M_SETHI  = 3'b001,
        OCC_M_SETLO  = 3'b010,
        OCC_M_TOGGLE = 3'b011,
        OCC_M_SINGLE = 3'b100,
        OCC_M_CONT   = 3'b101,
        OCC_M_PWM    = 3'b110,
        OCC_M_PWMF   = 3'b111
    } occ_mode_e;
endpackage

// ===== rtl/occ_match.sv
// timer source selection and compare match detection
`timescale 1ns/1ns
`default_nettype none
module occ_match (
    // timer counts
    input  wire logic [15:0] timer_a,
    input  wire logic [15:0] timer_b,
    input  wire logic [31:0] timer_wide,
    // selection
    input  wire logic        wide_sel,
    input  wire logic        tsel,
    // compare values
    input  wire logic [31:0] pri_val,
    input  wire logic [31:0] sec_val,
    // results
    output logic             pri_hit,
    output logic             sec_hit,
    output logic             period_start
);
    // narrow source from one of two timers
    wire [15:0] narrow_cnt = tsel ? timer_b : timer_a;
    wire [31:0] cnt        = wide_sel ? timer_wide : {16'h0000, narrow_cnt};

    function automatic logic eq(input logic w, input logic [31:0] a,
                                input logic [31:0] b);
        eq = w ? (a == b) : (a[15:0] == b[15:0]);
    endfunction

    assign pri_hit      = eq(wide_sel, cnt, pri_val);
    assign sec_hit      = eq(wide_sel, cnt, sec_val);
    assign period_start = (cnt == 32'h0000_0000);
endmodule
`default_nettype wire

// ===== rtl/occ_channel.sv
// output compare channel: control registers, modes, pwm and fault
// Behaviour
// - channel works only while enable bit 15 is one
// - stop-in-idle bit 13 halts channel during processor idle
// - wide select bit 5 picks 32-bit compare, else low 16 bits
// - fault flag bit 4 set by hardware, writes to bit 4 never clear it, a write that leaves mode 111 does
// - fault flag reads zero outside pwm-with-fault mode 111
// - timebase bit 3 picks second timer when one, first when zero; wide mode uses the 32-bit timer instead
// - mode 111 gives pwm and honours the fault input
// - mode 110 gives pwm and ignores the fault input
// - mode 101 starts low then repeats pulses
// - mode 100 starts low then gives exactly one pulse
// - mode 011 toggles output on every match
// - mode 010 starts high, match drives low
// - mode 001 starts low, match drives high
// - mode 000 disables compare function
// - control bits 31-16 and unimplemented control bits ignore writes, read zero; compare values keep all 32 bits
// - compare values against selected count, event on match, in pwm modes at period start instead of duty match
// - fault input a for channels one to four, b for five
// - clear, set, invert aliases at offsets 4, 8 and C
`timescale 1ns/1ns
`default_nettype none
module occ_channel #(
    parameter int CHANNEL = 1
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // timebase
    input  wire logic [15:0] timer_a,
    input  wire logic [15:0] timer_b,
    input  wire logic [31:0] timer_wide,
    input  wire logic        cpu_idle,
    // fault pins
    input  wire logic        fault_input_a,
    input  wire logic        fault_input_b,
    // outputs
    output logic             compare_output_pin,
    output logic             compare_event
);
    import occ_pkg::*;

    logic [31:0] compare_control;
    logic [31:0] primary_compare_value;
    logic [31:0] secondary_compare_value;
    logic [31:0] duty;
    logic        out_q;
    logic        pulse_done;
    logic        pulse_high;
    logic        fault_s1;
    logic        fault_s2;
    logic        pwm_fault_flag;
    logic [2:0]  last_mode;
    logic        last_enable;

    // register fields
    wire        enable     = compare_control[OCC_ON_BIT];
    wire        stop_idle  = compare_control[OCC_IDLE_BIT];
    wire        wide_sel   = compare_control[OCC_WIDE_BIT];
    wire        tsel       = compare_control[OCC_TSEL_BIT];
    wire [2:0]  compare_mode_field = compare_control[2:0];
    wire        run = enable && !(stop_idle && cpu_idle);
    wire        is_pwmf = (compare_mode_field == OCC_M_PWMF);
    wire        is_pwm  = (compare_mode_field == OCC_M_PWM) || is_pwmf;
    wire        is_pulse = (compare_mode_field == OCC_M_SINGLE) ||
                           (compare_mode_field == OCC_M_CONT);

    // fault pin choice depends on channel number
    wire fault_raw = (CHANNEL == 5) ? fault_input_b : fault_input_a;

    // compare unit
    logic pri_hit;
    logic sec_hit;
    logic period_start;
    occ_match u_match (
        .timer_a      (timer_a),
        .timer_b      (timer_b),
        .timer_wide   (timer_wide),
        .wide_sel     (wide_sel),
        .tsel         (tsel),
        .pri_val      (primary_compare_value),
        .sec_val      (duty),
        .pri_hit      (pri_hit),
        .sec_hit      (sec_hit),
        .period_start (period_start)
    );
    wire sec_raw_hit = wide_sel ?
        (timer_wide == secondary_compare_value) :
        ((tsel ? timer_b : timer_a) == secondary_compare_value[15:0]);

    // address decode; low nibble selects plain, clear, set or invert
    wire [3:0] base   = addr[7:4];
    wire [3:0] alias_ = addr[3:0];
    wire sel_ctrl = (base == OCC_CTRL_OFF[7:4]);
    wire sel_pri  = (base == OCC_PRI_OFF[7:4]);
    wire sel_sec  = (base == OCC_SEC_OFF[7:4]);

    // alias write function: plain, clear, set or invert
    function automatic logic [31:0] apply(input logic [31:0] cur,
                                          input logic [31:0] d,
                                          input logic [3:0] a);
        case (a)
            OCC_ALIAS_CLR: apply = cur & ~d;
            OCC_ALIAS_SET: apply = cur | d;
            OCC_ALIAS_INV: apply = cur ^ d;
            default:       apply = d;
        endcase
    endfunction

    wire [31:0] ctrl_new = apply(compare_control, wdata, alias_) &
                           OCC_CTRL_WMASK;
    wire [31:0] next_control = (wr && sel_ctrl) ? ctrl_new : compare_control;
    wire [31:0] next_pri = (wr && sel_pri) ?
        apply(primary_compare_value, wdata, alias_) : primary_compare_value;
    wire [31:0] next_sec = (wr && sel_sec) ?
        apply(secondary_compare_value, wdata, alias_) :
        secondary_compare_value;

    // register writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            compare_control         <= OCC_CTRL_RST;
            primary_compare_value   <= OCC_VAL_RST;
            secondary_compare_value <= OCC_VAL_RST;
        end else begin
            compare_control         <= next_control;
            primary_compare_value   <= next_pri;
            secondary_compare_value <= next_sec;
        end
    end

    // read data; flag only visible in mode 111
    wire flag_vis = pwm_fault_flag && is_pwmf;
    wire [31:0] ctrl_rd = compare_control |
                          ({31'h0, flag_vis} << OCC_FLT_BIT);
    wire [31:0] next_rdata =
        !rd      ? 32'h0000_0000 :
        sel_ctrl ? ctrl_rd :
        sel_pri  ? primary_compare_value :
        sel_sec  ? secondary_compare_value : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (!rst_n) rdata <= 32'h0000_0000;
        else        rdata <= next_rdata;
    end

    // fault pin synchroniser, two stages before use
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fault_s1 <= 1'b0;
            fault_s2 <= 1'b0;
        end else begin
            fault_s1 <= fault_raw;
            fault_s2 <= fault_s1;
        end
    end
    wire fault_hit = run && is_pwmf && fault_s2;

    // mode or enable change reinitialises the pin; an idle resume must not,
    // or a halted channel would lose the level it stopped with
    wire restart = (compare_mode_field != last_mode) ||
                   (enable && !last_enable);

    // initial level per mode
    function automatic logic init_level(input logic [2:0] m);
        init_level = (m == OCC_M_SETLO);
    endfunction

    // output level decision
    logic next_out;
    logic next_done;
    logic next_high;
    logic next_evt;
    always_comb begin
        next_out  = out_q;
        next_done = pulse_done;
        next_high = pulse_high;
        next_evt  = 1'b0;
        if (!enable || compare_mode_field == OCC_M_OFF) begin
            next_out  = 1'b0;
            next_done = 1'b0;
            next_high = 1'b0;
        end else if (restart) begin
            next_out  = init_level(compare_mode_field);
            next_done = 1'b0;
            next_high = 1'b0;
        end else if (!run) begin
            next_out = out_q; // hold while idle-stopped
        end else if (fault_hit) begin
            next_out = 1'b0;
            next_evt = !pwm_fault_flag;
        end else begin
            unique case (compare_mode_field)
                OCC_M_SETHI: if (pri_hit) begin
                    next_out = 1'b1;
                    next_evt = 1'b1;
                end
                OCC_M_SETLO: if (pri_hit) begin
                    next_out = 1'b0;
                    next_evt = 1'b1;
                end
                OCC_M_TOGGLE: if (pri_hit) begin
                    next_out = !out_q;
                    next_evt = 1'b1;
                end
                OCC_M_SINGLE, OCC_M_CONT: begin
                    if (!pulse_done && !pulse_high && pri_hit) begin
                        next_out  = 1'b1;
                        next_high = 1'b1;
                        next_evt  = 1'b1;
                    end else if (pulse_high && sec_raw_hit) begin
                        next_out  = 1'b0;
                        next_high = 1'b0;
                        next_evt  = 1'b1;
                        next_done = (compare_mode_field == OCC_M_SINGLE);
                    end
                end
                OCC_M_PWM, OCC_M_PWMF: begin
                    if (period_start) begin
                        next_out = 1'b1;
                        next_evt = 1'b1;
                    end else if (sec_hit) begin
                        next_out = 1'b0;
                    end
                end
                OCC_M_OFF: next_out = 1'b0;
            endcase
        end
    end

    // pwm duty reload at period boundary
    wire [31:0] next_duty = (!is_pwm || period_start || restart) ?
                            secondary_compare_value : duty;

    // flag: set by fault, cleared at period start once fault gone, or whenever mode is not 111
    wire next_flag = fault_hit ? 1'b1 :
                     (!is_pwmf || (!fault_s2 && period_start)) ? 1'b0 :
                     pwm_fault_flag;

    // channel state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_q          <= 1'b0;
            pulse_done     <= 1'b0;
            pulse_high     <= 1'b0;
            pwm_fault_flag <= 1'b0;
            duty           <= OCC_VAL_RST;
            last_mode      <= 3'b000;
            last_enable    <= 1'b0;
            compare_event  <= 1'b0;
        end else begin
            out_q          <= next_out;
            pulse_done     <= next_done;
            pulse_high     <= next_high;
            pwm_fault_flag <= next_flag;
            duty           <= next_duty;
            last_mode      <= compare_mode_field;
            last_enable    <= enable;
            compare_event  <= next_evt;
        end
    end
    assign compare_output_pin = out_q;

    // assertions
    chk_disable_low: assert property (@(posedge clk) disable iff (!rst_n)
        !enable |=> !compare_output_pin)
        else $error("output high while channel disabled");
    chk_idle_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (run == 1'b0 && enable && stop_idle && $stable(compare_mode_field)
         && !restart) |=> $stable(compare_output_pin))
        else $error("output changed during idle stop");
    chk_flag_hidden: assert property (@(posedge clk) disable iff (!rst_n)
        (rd && sel_ctrl && !is_pwmf) |=> !rdata[OCC_FLT_BIT])
        else $error("fault flag visible outside mode 111");
    chk_fault_drop: assert property (@(posedge clk) disable iff (!rst_n)
        fault_hit && !restart |=> !compare_output_pin && pwm_fault_flag)
        else $error("fault did not drop output");
    chk_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
        rd |=> rdata[31:16] == 16'h0000)
        else $error("upper bits read nonzero");
    chk_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        (pwm_fault_flag && wr && sel_ctrl && is_pwmf &&
         ctrl_new[2:0] == OCC_M_PWMF && !period_start) |=> pwm_fault_flag)
        else $error("software cleared fault flag");
    sequence s_toggle_hit;
        run && !restart && !fault_hit &&
        compare_mode_field == OCC_M_TOGGLE && pri_hit;
    endsequence
    chk_toggle: assert property (@(posedge clk) disable iff (!rst_n)
        s_toggle_hit |=> compare_output_pin != $past(compare_output_pin)
        && compare_event)
        else $error("toggle mode did not invert output");
    chk_mode_off: assert property (@(posedge clk) disable iff (!rst_n)
        compare_mode_field == OCC_M_OFF |=> !compare_output_pin)
        else $error("output active in mode 000");
endmodule
`default_nettype wire

// ===== tb/occ_load.sv
// external load on the compare output: counts rising edges of the pin
`timescale 1ns/1ns
`default_nettype none
module occ_load (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // observed pin
    input  wire logic        pin,
    // rising edge count
    output logic      [31:0] rises
);
    logic pin_q;

    // a purely passive load: it never drives anything back
    always_ff @(posedge clk) begin
        pin_q <= pin;
        if (!rst_n) begin
            rises <= 32'h0;
        end else if (pin && !pin_q) begin
            rises <= rises + 32'h1;
        end
    end
endmodule
`default_nettype wire

// ===== tb/test_output_compare_channel.sv
// testbench of the output compare channel
`timescale 1ns/1ns
`default_nettype none
module test_output_compare_channel;
    import occ_pkg::*;
    logic        clk, rst_n, wr, rd, cpu_idle, flt_a, flt_b, pin, ev;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, tw, rises, n_ev;
    logic [15:0] ta, tb;
    int          n_fail, n_checks, k;

    occ_channel #(.CHANNEL(1)) i_dut (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .timer_a(ta),
        .timer_b(tb), .timer_wide(tw), .cpu_idle(cpu_idle),
        .fault_input_a(flt_a), .fault_input_b(flt_b),
        .compare_output_pin(pin), .compare_event(ev));
    occ_load i_load (.clk(clk), .rst_n(rst_n), .pin(pin), .rises(rises));

    // event pulses counted by the bench, not by the load
    always_ff @(posedge clk) begin
        if (!rst_n) n_ev <= 32'h0;
        else if (ev) n_ev <= n_ev + 32'h1;
    end

    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", rdata, e);
    endtask
    task automatic cfg(input logic [31:0] c);
        wr_reg(OCC_CTRL_OFF, c);
        // gap after every control write, so no access follows enable-off
        repeat (3) @(posedge clk);
    endtask
    // one cycle of matching counts, then back to a value that never matches
    task automatic hit(input logic [15:0] a, b, input logic [31:0] w);
        @(posedge clk);
        ta <= a;
        tb <= b;
        tw <= w;
        @(posedge clk);
        ta <= 16'h7777;
        tb <= 16'h7777;
        tw <= 32'h7777_7777;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic pin_is(input logic e);
        chk("pin", {31'h0, pin}, {31'h0, e});
    endtask

    task automatic t_regs;
        rd_chk(OCC_CTRL_OFF, OCC_CTRL_RST);
        wr_reg(OCC_CTRL_OFF, 32'hFFFF_FFFF);
        rd_chk(OCC_CTRL_OFF, 32'h0000_A02F);
        wr_reg(OCC_CTRL_OFF | OCC_ALIAS_CLR, 32'h0000_2003);
        rd_chk(OCC_CTRL_OFF, 32'h0000_802C);
        wr_reg(OCC_CTRL_OFF | OCC_ALIAS_SET, 32'h0000_2000);
        wr_reg(OCC_CTRL_OFF | OCC_ALIAS_INV, 32'h0000_0028);
        rd_chk(OCC_CTRL_OFF, 32'h0000_A004);
        rd_chk(8'h30, 32'h0);
        wr_reg(OCC_PRI_OFF, 32'h0001_0005);
        wr_reg(OCC_SEC_OFF, 32'h0000_0009);
        rd_chk(OCC_SEC_OFF, 32'h0000_0009);
    endtask
    // set-high, set-low, toggle: initial level and level after match; off: no event on match
    task automatic t_simple;
        logic [31:0] e0;
        for (k = 1; k <= 3; k++) begin
            cfg(32'h8000 | k);
            pin_is(k == 2);
            e0 = n_ev;
            hit(16'h5, 16'h7777, 32'h7777_7777);
            pin_is(k != 2);
            chk("events", n_ev, e0 + 32'h1);
        end
        hit(16'h5, 16'h7777, 32'h7777_7777);
        pin_is(1'b0);
        cfg(32'h8000);
        e0 = n_ev;
        hit(16'h5, 16'h7777, 32'h7777_7777);
        chk("events", n_ev, e0);
    endtask
    // timer source and width selection
    task automatic t_select;
        cfg(32'h8009);
        hit(16'h5, 16'h7777, 32'h7777_7777);
        pin_is(1'b0);
        hit(16'h7777, 16'h5, 32'h7777_7777);
        pin_is(1'b1);
        // pass through mode 000 so the next mode 001 starts low again
        cfg(32'h8000);
        pin_is(1'b0);
        cfg(32'h8021);
        hit(16'h5, 16'h5, 32'h0000_0005);
        pin_is(1'b0);
        hit(16'h7777, 16'h7777, 32'h0001_0005);
        pin_is(1'b1);
    endtask
    // enable and stop-in-idle
    task automatic t_enable;
        cfg(32'h0001);
        hit(16'h5, 16'h7777, 32'h7777_7777);
        pin_is(1'b0);
        cpu_idle <= 1'b1;
        cfg(32'hA001);
        hit(16'h5, 16'h7777, 32'h7777_7777);
        pin_is(1'b0);
        cfg(32'h8001);
        hit(16'h5, 16'h7777, 32'h7777_7777);
        pin_is(1'b1);
        cpu_idle <= 1'b0;
    endtask
    // pulse modes: rise on primary, fall on secondary
    task automatic t_pulse;
        logic [31:0] r0;
        for (k = 4; k <= 5; k++) begin
            cfg(32'h8000 | k);
            pin_is(1'b0);
            r0 = rises;
            hit(16'h5, 16'h7777, 32'h7777_7777);
            pin_is(1'b1);
            hit(16'h9, 16'h7777, 32'h7777_7777);
            pin_is(1'b0);
            hit(16'h5, 16'h7777, 32'h7777_7777);
            chk("rises", rises, r0 + ((k == 5) ? 32'h2 : 32'h1));
        end
    endtask
    // pwm with and without fault handling
    task automatic t_pwm;
        logic [31:0] e0;
        cfg(32'h8006);
        flt_a <= 1'b1;
        hit(16'h0, 16'h7777, 32'h7777_7777);
        pin_is(1'b1);
        rd_chk(OCC_CTRL_OFF, 32'h0000_8006);
        hit(16'h9, 16'h7777, 32'h7777_7777);
        pin_is(1'b0);
        flt_a <= 1'b0;
        cfg(32'h8007);
        hit(16'h0, 16'h7777, 32'h7777_7777);
        flt_b <= 1'b1;
        repeat (6) @(posedge clk);
        pin_is(1'b1);
        e0 = n_ev;
        flt_a <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        pin_is(1'b0);
        chk("events", n_ev, e0 + 32'h1);
        // fault gone first, so only the write could clear the flag now
        flt_a <= 1'b0;
        flt_b <= 1'b0;
        repeat (4) @(posedge clk);
        wr_reg(OCC_CTRL_OFF | OCC_ALIAS_CLR, 32'h0000_0010);
        rd_chk(OCC_CTRL_OFF, 32'h0000_8017);
        hit(16'h0, 16'h7777, 32'h7777_7777);
        pin_is(1'b1);
        rd_chk(OCC_CTRL_OFF, 32'h0000_8007);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        // about two hundred cycles of tests; ten thousand means a hang
        #200000;
        n_fail++;
        wrap_up();
    end
    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h0;
        wdata = 32'h0;
        ta = 16'h7777;
        tb = 16'h7777;
        tw = 32'h7777_7777;
        cpu_idle = 1'b0;
        flt_a = 1'b0;
        flt_b = 1'b0;
        n_fail = 0;
        n_checks = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_simple();
        t_select();
        t_enable();
        t_pulse();
        t_pwm();
        wrap_up();
    end
endmodule
`default_nettype wire
